// ==== rtl/buck_one_regs.sv ====
/*
 * Setup and control register bank for the buck_one regulator, reached
 * over the two-wire serial control bus, with set-point selection, the
 * voltage ramp and the phased switching clock.
 * Assumes SCL/SDA and the mode pins are asynchronous to MCLK_IN and
 * that a board-level pull-up resolves SDA when no one drives it.
 */
// Overview of operation
// - Each 6-bit code means 300 mV plus 25 mV per step, up to 1875 mV.
// - Normal, standby and sleep set points are kept apart; the one of the current mode is used.
// - The normal set point lives in bits 5:0 at 0x20, resets to zero.
// - The standby set point lives in bits 5:0 at 0x21, resets to zero.
// - The sleep set point lives in bits 5:0 at 0x22, resets to zero.
// - The switching mode comes from bits 3:0 of the mode register at 0x23.
// - In sleep, mode bit 5 low turns the regulator off, high runs it in PFM.
// - Config bit 0 low picks the high current limit, high the low one.
// - Config bits 3:2 pick the switching frequency, default zero.
// - Config bits 5:4 pick the switching clock phase, default zero.
// - Config bits 7:6 pick the ramp speed, default zero.
// - Frequency codes 0,1,2 give 1, 2 and 4 MHz; code 3 is reserved.
// - Phase codes 0 to 3 shift the switching clock by 0 to 270 degrees at every frequency, which is 0 to 750 ns only at 1 MHz.
// - Ramp codes 0 to 3 step 25 mV every 2, 4, 8 or 16 us.
`timescale 1ns/1ps
`default_nettype none
module buck_one_regs
    import buck_one_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h08 // Arbitrary bus address
) (
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic RESETN_IN,
    // Serial control bus pins
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    // Operating mode pins
    input wire logic STANDBY_IN,
    input wire logic SLEEP_IN,
    // Regulator controls
    output target_t TARGET_OUT,
    output logic REG_EN_OUT,
    output logic PFM_OUT,
    output logic [MODE_W-1:0] SW_MODE_OUT,
    output config_t CONF_OUT,
    output logic SW_CLK_OUT
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR,
        ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
    } bus_state_t;

    bus_state_t state_q;
    logic [2:0] scl_s, sda_s;
    logic [1:0] stby_s, slp_s;
    logic [3:0] cnt_q;
    logic [7:0] shift_q, ptr_q, rd_data;
    logic rw_q, nack_q, drv_low_q, wr_stb_q;
    logic [SETPT_W-1:0] setpt_q [3];
    logic [MODE_W-1:0] mode_q;
    logic sleep_pfm_q;
    config_t cfg_q;
    logic [SETPT_W-1:0] act_code, code_d;
    logic [11:0] ramp_cnt_q, ramp_int;
    logic [7:0] acc_q;
    logic [8:0] acc_sum, pos_sum;
    logic sw_clk_q;
    logic scl_rise, scl_fall, start_ev, stop_ev;

    // Pin synchronisers; index 2 is an edge-detect delay stage
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            stby_s <= 2'h0;
            slp_s <= 2'h0;
        end else begin
            scl_s <= {scl_s[1:0], SCL_IN};
            sda_s <= {sda_s[1:0], SDA_IN};
            stby_s <= {stby_s[0], STANDBY_IN};
            slp_s <= {slp_s[0], SLEEP_IN};
        end
    end

    assign scl_rise = scl_s[1] & ~scl_s[2];
    assign scl_fall = ~scl_s[1] & scl_s[2];
    assign start_ev = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
    assign stop_ev = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

    // Bus engine: bits sampled on SCL rise, SDA changed on SCL fall
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
            drv_low_q <= 1'b0;
            wr_stb_q <= 1'b0;
        end else begin
            wr_stb_q <= 1'b0;
            if (start_ev) begin
                state_q <= ST_ADDR;
                cnt_q <= 4'h0;
                drv_low_q <= 1'b0;
            end else if (stop_ev) begin
                state_q <= ST_IDLE;
                drv_low_q <= 1'b0;
            end else if (scl_rise) begin
                case (state_q)
                    ST_ADDR, ST_PTR, ST_WR: begin
                        shift_q <= {shift_q[6:0], sda_s[1]};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    ST_ACK_RD: nack_q <= sda_s[1];
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (state_q)
                    ST_ADDR: begin
                        if (cnt_q == 4'h8) begin
                            if (shift_q[7:1] == DEV_ADDR) begin
                                state_q <= ST_ACK_ADDR;
                                rw_q <= shift_q[0];
                                drv_low_q <= 1'b1;
                            end else begin
                                state_q <= ST_IDLE; // Not for us
                            end
                        end
                    end
                    ST_ACK_ADDR: begin
                        cnt_q <= 4'h0;
                        if (rw_q) begin
                            shift_q <= rd_data;
                            drv_low_q <= ~rd_data[7];
                            state_q <= ST_RD;
                        end else begin
                            drv_low_q <= 1'b0;
                            state_q <= ST_PTR;
                        end
                    end
                    ST_PTR: begin
                        if (cnt_q == 4'h8) begin
                            ptr_q <= shift_q;
                            drv_low_q <= 1'b1;
                            state_q <= ST_ACK_PTR;
                        end
                    end
                    ST_ACK_PTR, ST_ACK_WR: begin
                        drv_low_q <= 1'b0;
                        cnt_q <= 4'h0;
                        if (state_q == ST_ACK_WR) begin
                            ptr_q <= ptr_q + 8'h01; // Burst writes
                        end
                        state_q <= ST_WR;
                    end
                    ST_WR: begin
                        if (cnt_q == 4'h8) begin
                            wr_stb_q <= 1'b1;
                            drv_low_q <= 1'b1;
                            state_q <= ST_ACK_WR;
                        end
                    end
                    ST_RD: begin
                        if (cnt_q == 4'h7) begin
                            drv_low_q <= 1'b0; // Host drives ack
                            ptr_q <= ptr_q + 8'h01;
                            state_q <= ST_ACK_RD;
                        end else begin
                            cnt_q <= cnt_q + 4'h1;
                            shift_q <= {shift_q[6:0], 1'b0};
                            drv_low_q <= ~shift_q[6];
                        end
                    end
                    ST_ACK_RD: begin
                        if (nack_q) begin
                            state_q <= ST_IDLE;
                        end else begin
                            shift_q <= rd_data;
                            drv_low_q <= ~rd_data[7];
                            cnt_q <= 4'h0;
                            state_q <= ST_RD;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Open-drain: the data level is always low, only the enable moves
    assign SDA_OUT = 1'b0;
    assign SDA_OE_OUT = drv_low_q;

    // Set-point registers, one per operating mode
    for (genvar g = 0; g < 3; g++) begin : g_setpt
        always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
            if (!RESETN_IN) begin
                setpt_q[g] <= SETPT_RST[SETPT_W-1:0];
            end else if (wr_stb_q &&
                         ptr_q == 8'(NORMAL_SETPT_ADDR + g)) begin
                setpt_q[g] <= shift_q[SETPT_W-1:0];
            end
        end
    end

    // Mode and configuration registers
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            mode_q <= MODE_RST[MODE_W-1:0];
            sleep_pfm_q <= MODE_RST[SLEEP_SEL_BIT];
            cfg_q <= CONFIG_RST;
        end else if (wr_stb_q) begin
            if (ptr_q == MODE_ADDR) begin
                mode_q <= shift_q[MODE_W-1:0];
                sleep_pfm_q <= shift_q[SLEEP_SEL_BIT];
            end
            if (ptr_q == CONFIG_ADDR) begin
                cfg_q <= shift_q;
            end
        end
    end

    // Read-back; unmapped offsets and unused mode bits read zero, config spare bit 1 reads as written
    always_comb begin
        case (ptr_q)
            NORMAL_SETPT_ADDR: rd_data = {2'h0, setpt_q[0]};
            STANDBY_SETPT_ADDR: rd_data = {2'h0, setpt_q[1]};
            SLEEP_SETPT_ADDR: rd_data = {2'h0, setpt_q[2]};
            MODE_ADDR: rd_data = {2'h0, sleep_pfm_q, 1'b0, mode_q};
            CONFIG_ADDR: rd_data = cfg_q;
            default: rd_data = 8'h00;
        endcase
    end

    // Set point of the mode in force; sleep outranks standby
    always_comb begin
        if (slp_s[1]) begin
            act_code = setpt_q[2];
        end else if (stby_s[1]) begin
            act_code = setpt_q[1];
        end else begin
            act_code = setpt_q[0];
        end
        ramp_int = 12'(RAMP_CYC << cfg_q.ramp);
        code_d = TARGET_OUT.code;
        if (ramp_cnt_q == ramp_int - 12'h001) begin
            if (act_code > TARGET_OUT.code) begin
                code_d = TARGET_OUT.code + 6'h01;
            end else if (act_code < TARGET_OUT.code) begin
                code_d = TARGET_OUT.code - 6'h01;
            end
        end
    end

    // Ramp: one code step per interval so load sees a controlled slope
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ramp_cnt_q <= 12'h000;
            TARGET_OUT <= '{code: SETPT_RST[SETPT_W-1:0],
                            mv: 11'(BASE_MV)};
        end else begin
            if (act_code == TARGET_OUT.code ||
                ramp_cnt_q >= ramp_int - 12'h001) begin
                ramp_cnt_q <= 12'h000;
            end else begin
                ramp_cnt_q <= ramp_cnt_q + 12'h001;
            end
            TARGET_OUT.code <= code_d;
            TARGET_OUT.mv <= 11'(BASE_MV + STEP_MV * code_d);
        end
    end

    // Regulator state and static controls
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            REG_EN_OUT <= 1'b1;
            PFM_OUT <= 1'b0;
            SW_MODE_OUT <= MODE_RST[MODE_W-1:0];
            CONF_OUT <= CONFIG_RST;
        end else begin
            REG_EN_OUT <= !(slp_s[1] && !sleep_pfm_q);
            PFM_OUT <= slp_s[1] && sleep_pfm_q;
            SW_MODE_OUT <= mode_q;
            CONF_OUT <= cfg_q;
        end
    end

    // Phase accumulator over one 1 MHz period; faster rates step faster
    // so every frequency, and every phase at 1 and 2 MHz, lands on an exact cycle.
    assign acc_sum = {1'b0, acc_q} + (9'h001 << cfg_q.freq);
    assign pos_sum = {1'b0, acc_q} + 9'(cfg_q.phase * 50);
    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            acc_q <= 8'h00;
            sw_clk_q <= 1'b0;
        end else begin
            if (acc_sum >= 9'(SW_PERIOD_CYC)) begin
                acc_q <= 8'(acc_sum - 9'(SW_PERIOD_CYC));
            end else begin
                acc_q <= acc_sum[7:0];
            end
            if (cfg_q.freq == FREQ_RESERVED) begin
                sw_clk_q <= 1'b0; // Reserved code parks the clock
            end else if (pos_sum >= 9'(SW_PERIOD_CYC)) begin
                sw_clk_q <= (pos_sum - 9'(SW_PERIOD_CYC)) <
                            9'(SW_PERIOD_CYC / 2);
            end else begin
                sw_clk_q <= pos_sum < 9'(SW_PERIOD_CYC / 2);
            end
        end
    end
    assign SW_CLK_OUT = sw_clk_q;

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    volt_map_a: assert property (
        TARGET_OUT.mv == 11'(BASE_MV + STEP_MV * TARGET_OUT.code))
        else $error("Target millivolts do not match code");
    sleep_sel_a: assert property (
        slp_s[1] |-> act_code == setpt_q[2])
        else $error("Sleep set point not selected");
    normal_wr_a: assert property (
        wr_stb_q && ptr_q == NORMAL_SETPT_ADDR |=>
        setpt_q[0] == $past(shift_q[5:0]))
        else $error("Normal set point not written");
    mode_wr_a: assert property (
        wr_stb_q && ptr_q == MODE_ADDR |=> ##1
        SW_MODE_OUT == $past(shift_q[3:0], 2))
        else $error("Switching mode not taken");
    sleep_off_a: assert property (
        slp_s[1] && !sleep_pfm_q |=> !REG_EN_OUT && !PFM_OUT)
        else $error("Regulator not off in sleep");
    conf_wr_a: assert property (
        wr_stb_q && ptr_q == CONFIG_ADDR |=> ##1
        CONF_OUT == $past(shift_q, 2))
        else $error("Config not taken");
    freq_park_a: assert property (
        cfg_q.freq == FREQ_RESERVED |=> !SW_CLK_OUT)
        else $error("Clock runs on reserved code");
    ramp_step_a: assert property (
        TARGET_OUT.code != $past(TARGET_OUT.code) |->
        $past(ramp_cnt_q) == $past(ramp_int) - 12'h001)
        else $error("Ramp stepped off interval");
    unused_rd_a: assert property (
        ptr_q == MODE_ADDR |-> rd_data[7:6] == 2'h0 && !rd_data[4])
        else $error("Unused mode bits read nonzero");

    wr_cov_c: cover property (wr_stb_q && ptr_q == SLEEP_SETPT_ADDR);
    rd_cov_c: cover property (state_q == ST_ACK_RD && scl_fall && !nack_q);
    ramp_cov_c: cover property (TARGET_OUT.code != $past(TARGET_OUT.code));
    pfm_cov_c: cover property (PFM_OUT);
endmodule
`default_nettype wire

// ==== rtl/buck_one_pkg.sv ====
/*
 * Shared constants and carriers for the buck_one setup register bank.
 * Assumes a 200 MHz core clock; all cycle counts derive from its period.
 */
package buck_one_pkg;
    // Register offsets on the control bus
    localparam logic [7:0] NORMAL_SETPT_ADDR = 8'h20;
    localparam logic [7:0] STANDBY_SETPT_ADDR = 8'h21;
    localparam logic [7:0] SLEEP_SETPT_ADDR = 8'h22;
    localparam logic [7:0] MODE_ADDR = 8'h23;
    localparam logic [7:0] CONFIG_ADDR = 8'h24;
    // Values after reset
    localparam logic [7:0] SETPT_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h80;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    // Field layout
    localparam int SETPT_W = 6;
    localparam int MODE_W = 4;
    localparam int SLEEP_SEL_BIT = 5;
    // Voltage coding in millivolts
    localparam int BASE_MV = 300;
    localparam int STEP_MV = 25;
    // Clock period and derived cycle counts
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RAMP_FAST_NS = 2000;
    localparam int RAMP_CYC = (RAMP_FAST_NS * 1000) / CLK_PERIOD_PS;
    localparam int SW_BASE_KHZ = 1000;
    localparam int SW_PERIOD_CYC =
        1000000000 / (SW_BASE_KHZ * CLK_PERIOD_PS);
    localparam logic [1:0] FREQ_RESERVED = 2'h3;
    // Configuration register fields, msb first
    typedef struct packed {
        logic [1:0] ramp;
        logic [1:0] phase;
        logic [1:0] freq;
        logic spare;
        logic ilim_low;
    } config_t;
    // Target handed to the analog regulator
    typedef struct packed {
        logic [SETPT_W-1:0] code;
        logic [10:0] mv;
    } target_t;
endpackage

// ==== sim/i2c_host_model.sv ====
/*
 * Behavioural two-wire bus host that programs the buck_one bank.
 * Assumes SDA is resolved outside with a pull-up and fed back here.
 */
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
    parameter logic [6:0] DEV = 7'h08
) (
    // Core clock paces every bus phase
    input wire logic mclk_in,
    input wire logic sda_line_in,
    // Bus lines driven by the host, high means released
    output logic scl_out,
    output logic sda_out
);
    // Bus idles released
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic clk(int n);
        repeat (n) @(posedge mclk_in);
    endtask
    // One bit; 8-cycle phases stay well above the 4-cycle minimum
    task automatic bit_io(logic b, output logic r);
        clk(2);
        sda_out <= b;
        clk(6);
        scl_out <= 1'b1;
        clk(4);
        r = sda_line_in;
        clk(4);
        scl_out <= 1'b0;
    endtask
    task automatic byte_tx(logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // Last byte is answered with a nack to end the read
    task automatic byte_rx(logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask
    // Works from idle and as a repeated start
    task automatic start();
        clk(4);
        sda_out <= 1'b1;
        clk(4);
        scl_out <= 1'b1;
        clk(4);
        sda_out <= 1'b0;
        clk(4);
        scl_out <= 1'b0;
    endtask
    task automatic stop();
        clk(2);
        sda_out <= 1'b0;
        clk(6);
        scl_out <= 1'b1;
        clk(4);
        sda_out <= 1'b1;
        clk(8);
    endtask
    task automatic write_reg(logic [6:0] dev, logic [7:0] a, logic [7:0] d,
                             output logic ok);
        logic k1, k2, k3;
        // Codes at or below 0.6 V are never sent to a set point
        if (a >= 8'h20 && a <= 8'h22 && d[5:0] <= 6'h0c) begin
            d[5:0] = 6'h0d;
        end
        start();
        byte_tx({dev, 1'b0}, k1);
        byte_tx(a, k2);
        byte_tx(d, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask
    // Pointer write, then repeated start and a one-byte read
    task automatic read_reg(logic [7:0] a, output logic [7:0] d,
                            output logic ok);
        logic k1, k2, k3;
        start();
        byte_tx({DEV, 1'b0}, k1);
        byte_tx(a, k2);
        start();
        byte_tx({DEV, 1'b1}, k3);
        byte_rx(1'b1, d);
        stop();
        ok = k1 & k2 & k3;
    endtask
endmodule
`default_nettype wire

// ==== sim/tb_buck_one_regs.sv ====
/*
 * Self-checking bench for buck_one_regs: register access, ramp,
 * mode pins and switching clock.
 * Assumes the host model in sim/ and a pull-up on SDA.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_buck_one_regs;
    import buck_one_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic standby = 1'b0;
    logic sleep = 1'b0;
    wire logic scl;
    wire logic sda_host;
    wire logic sda_line;
    logic sda_dev, sda_oe, reg_en, pfm, sw_clk, ack;
    target_t target;
    logic [MODE_W-1:0] sw_mode;
    config_t conf;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int t0, t1, hi;
    logic [7:0] rd, d;
    logic [5:0] code [3];
    // Wired-AND with pull-up: device low only while enabled
    assign sda_line = sda_host & ~(sda_oe & ~sda_dev);
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;
    buck_one_regs dut_u (
        .MCLK_IN(mclk), .RESETN_IN(resetn),
        .SCL_IN(scl), .SDA_IN(sda_line),
        .SDA_OUT(sda_dev), .SDA_OE_OUT(sda_oe),
        .STANDBY_IN(standby), .SLEEP_IN(sleep),
        .TARGET_OUT(target), .REG_EN_OUT(reg_en), .PFM_OUT(pfm),
        .SW_MODE_OUT(sw_mode), .CONF_OUT(conf), .SW_CLK_OUT(sw_clk)
    );
    i2c_host_model host_u (
        .mclk_in(mclk), .sda_line_in(sda_line),
        .scl_out(scl), .sda_out(sda_host)
    );
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] v);
        host_u.write_reg(7'h08, a, v, ack);
        check("write ack", 1, ack);
    endtask
    task automatic rdchk(logic [7:0] a, logic [7:0] exp);
        host_u.read_reg(a, rd, ack);
        check("read ack", 1, ack);
        check("read data", exp, rd);
    endtask
    // Unused bits read zero; config bit 1 is stored as printed
    function automatic logic [7:0] rb(logic [7:0] a, logic [7:0] v);
        case (a)
            8'h20, 8'h21, 8'h22: return v & 8'h3f;
            8'h23: return v & 8'h2f;
            8'h24: return v;
            default: return 8'h00;
        endcase
    endfunction
    // Bounded wait for the ramp to reach a code, then its millivolts
    task automatic wait_code(logic [5:0] c, int lim);
        int n;
        n = 0;
        // Look off the launching edge so the ramp output has settled
        @(negedge mclk);
        while (target.code !== c && n < lim) begin
            @(negedge mclk);
            n++;
        end
        check("target code", c, target.code);
        check("target mv", 11'(300 + 25 * c), target.mv);
    endtask
    task automatic next_rise(output int t);
        int n;
        n = 0;
        @(negedge mclk);
        while (sw_clk !== 1'b0 && n < 400) begin
            @(negedge mclk);
            n++;
        end
        while (sw_clk !== 1'b1 && n < 400) begin
            @(negedge mclk);
            n++;
        end
        t = cyc;
    endtask
    // Main sequence
    initial begin
        void'($urandom(32'h32d9));
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        check("reset target", {6'h00, 11'h12c}, target);
        check("reset conf", 8'h00, conf);
        check("reset en", 1, reg_en);
        for (int a = 8'h20; a <= 8'h25; a++) begin
            rdchk(8'(a), 8'h00);
        end
        // Wrong device address is ignored
        host_u.write_reg(7'h09, 8'h20, 8'h3f, ack);
        check("wrong addr ack", 0, ack);
        rdchk(8'h20, 8'h00);
        repeat (2) begin
            for (int a = 8'h20; a <= 8'h25; a++) begin
                d = 8'($urandom);
                if (a <= 8'h22) d[5:0] = 6'h0d + 6'($urandom % 20);
                wr(8'(a), d);
                rdchk(8'(a), rb(8'(a), d));
                if (a == 8'h23) check("sw mode", d[3:0], sw_mode);
                if (a == 8'h24) check("conf", d, conf);
            end
        end
        // Set points per operating mode
        wr(CONFIG_ADDR, 8'h00);
        wr(MODE_ADDR, 8'h20);
        for (int i = 0; i < 3; i++) begin
            // Disjoint ranges, so every mode change really moves the ramp
            code[i] = 6'h0d + 6'(7 * i + $urandom % 7);
            wr(8'(8'h20 + i), {2'b00, code[i]});
        end
        wait_code(code[0], 9000);
        @(posedge mclk);
        standby <= 1'b1;
        wait_code(code[1], 9000);
        @(posedge mclk);
        sleep <= 1'b1;
        wait_code(code[2], 9000);
        check("pfm on", 1, pfm);
        check("en pfm", 1, reg_en);
        wr(MODE_ADDR, 8'h00);
        repeat (8) @(negedge mclk);
        check("pfm off", 0, pfm);
        check("en off", 0, reg_en);
        @(posedge mclk);
        sleep <= 1'b0;
        standby <= 1'b0;
        wait_code(code[0], 9000);
        // Step spacing for each ramp speed code
        for (int r = 0; r < 4; r++) begin
            wr(CONFIG_ADDR, 8'(r << 6));
            code[0] = code[0] + 6'h02;
            wr(NORMAL_SETPT_ADDR, {2'b00, code[0]});
            wait_code(code[0] - 6'h01, 7000);
            t0 = cyc;
            wait_code(code[0], 7000);
            check("ramp interval", 400 << r, cyc - t0);
        end
        // Switching clock period per frequency code
        for (int f = 0; f < 3; f++) begin
            wr(CONFIG_ADDR, 8'(f << 2));
            repeat (300) @(posedge mclk);
            next_rise(t0);
            next_rise(t1);
            check("sw period", 200 >> f, t1 - t0);
        end
        wr(CONFIG_ADDR, 8'h0c);
        repeat (10) @(posedge mclk);
        hi = 0;
        repeat (400) begin
            @(negedge mclk);
            hi += int'(sw_clk !== 1'b0);
        end
        check("reserved freq", 0, hi);
        // Phase code leads the 1 MHz clock by a quarter period per step
        wr(CONFIG_ADDR, 8'h00);
        next_rise(t0);
        for (int p = 1; p < 4; p++) begin
            wr(CONFIG_ADDR, 8'(p << 4));
            next_rise(t1);
            check("sw phase", 200 - 50 * p, (t1 - t0) % 200);
        end
        // Mid-run reset returns the bank to its defaults
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(negedge mclk);
        check("rerun conf", 8'h00, conf);
        check("rerun target", {6'h00, 11'h12c}, target);
        rdchk(CONFIG_ADDR, 8'h00);
        print_verdict();
    end
    // Roughly 70k cycles of traffic and ramps are expected
    initial begin
        repeat (95000) @(posedge mclk);
        n_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
